/* File: vdcr_pkg.sv */
// Package for the video decoder control register bank.
// Assumes a single 100 MHz clock and an Avalon-MM slave port.
package vdcr_pkg;
    localparam logic [7:0] IDX_CC_CTRL = 8'h0d;
    localparam logic [7:0] IDX_WSS_HI = 8'h0e;
    localparam logic [7:0] IDX_WSS_LO = 8'h0f;
    localparam logic [7:0] IDX_BRIGHTNESS_OFFSET = 8'h10;
    localparam logic [7:0] IDX_CONTR = 8'h11;
    localparam logic [7:0] IDX_SHARP = 8'h12;
    localparam logic [7:0] IDX_CB_GAIN = 8'h13;
    localparam logic [7:0] IDX_CR_GAIN = 8'h14;
    localparam logic [7:0] IDX_HUE = 8'h15;
    localparam logic [7:0] IDX_VPEAK = 8'h17;
    localparam logic [7:0] IDX_CORING = 8'h18;
    localparam logic [7:0] IDX_DELTA = 8'h19;
    localparam logic [7:0] IDX_CC_STAT = 8'h1a;
    localparam logic [7:0] IDX_CAPTION_DATA = 8'h1b;
    localparam logic [7:0] IDX_STD_SEL = 8'h1c;
    localparam logic [7:0] IDX_STD_REC = 8'h1d;
    localparam logic [7:0] IDX_COMP = 8'h1e;
    localparam logic [7:0] IDX_TEST = 8'h1f;
    localparam logic [7:0] IDX_CLAMP = 8'h20;
    localparam logic [7:0] IDX_AGC_LOOP_GAINS = 8'h21;
    localparam logic [7:0] IDX_AGC_LO = 8'h22;
    localparam logic [7:0] IDX_WHITE_PEAK_THRESHOLD = 8'h23;
    localparam logic [7:0] IDX_AGC_CTRL = 8'h06;
    localparam logic [7:0] RST_CC_CTRL = 8'h15;
    localparam logic [7:0] RST_CONTR = 8'h5c;
    localparam logic [7:0] RST_SHARP = 8'h11;
    localparam logic [7:0] RST_GAIN = 8'h80;
    localparam logic [7:0] RST_VPEAK = 8'h30;
    localparam logic [7:0] RST_CORING = 8'h44;
    localparam logic [3:0] RST_STD_SEL = 4'hf;
    localparam logic [6:0] RST_STD_REC = 7'h7f;
    localparam logic [3:0] RST_COMP = 4'h8;
    localparam logic [7:0] RST_CLAMP = 8'h50;
    localparam logic [7:0] RST_AGC_LOOP_GAINS = 8'h42;
    localparam logic [7:0] RST_AGC_LO = 8'hf0;
    localparam logic [7:0] RST_WHITE_PEAK_THRESHOLD = 8'hd8;
    localparam logic [2:0] STD_AUTO = 3'h7;
    localparam logic [3:0] COMP_AUTO = 4'h8;
    localparam logic [7:0] TEST_IN = 8'h04;
    localparam logic [7:0] TEST_OUT = 8'h07;
    localparam logic [7:0] UNITY_CONTR = 8'h40;
    localparam int CLAMP_STEP = 8;
    localparam int FIFO_DEPTH = 16;
    typedef struct packed {logic valid; logic [13:0] bits; logic field_even; logic crc_ok;} vdcr_wss_t;
    typedef struct packed {
        logic valid; logic [7:0] data; logic is_eds; logic high; logic field_even; logic [8:0] line;
    } vdcr_cc_t;
    typedef struct packed {logic valid; logic [7:0] y; logic [7:0] cb; logic [7:0] cr;} vdcr_pix_t;
    typedef struct packed {logic parity_err; logic is_eds; logic high; logic [7:0] data;} vdcr_ent_t;
    typedef enum logic {VDCR_IDLE, VDCR_SEEK} vdcr_state_t;
endpackage

/* File: vdcr_regs.sv */
// Control and status registers of the video decoder back end.
// Assumes an Avalon-MM master with word-aligned byte addresses, and slicer, picture
// and detector signals synchronous to the same clock.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
// Functional notes
// - WSS captured only while decoding enabled.
// - Odd-field caption taken from programmed line.
// - WSS CRC failure reported as one.
// - WSS field flag: odd zero, even one.
// - Fourteen WSS bits split across two registers.
// - Brightness adds signed offset to luma.
// - Contrast gain, 0x40 is unity, reset 5Ch.
// - Separate Cb and Cr gains, reset 80h.
// - Hue signed, positive toward red.
// - EDS and CC bytes stored only when enabled.
// - Parity flag marks odd parity error.
// - Overflow flag set when FIFO overflows.
// - Not-empty flag shows data available.
// - Source and byte-half flags accompany data.
// - Activity, current standard, select resets auto.
// - Shadow copies used when shadow_disable clear.
// - Auto detect start bit self-clears.
// - Detection accepts only enabled standards.
// - Component format detected, select, auto default.
// - Test register zero normally; 04h/07h routings.
// - Clamp pulse start/end in 8-clock steps.
// - Nine-bit manual gain, low byte F0h.
// - AGC loop used unless disabled.
module vdcr_regs (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input vdcr_pkg::vdcr_wss_t wss_in,
    input vdcr_pkg::vdcr_cc_t cc_in,
    input wire logic [2:0] std_measured,
    input wire logic std_measured_valid,
    input wire logic [2:0] component_detected,
    input vdcr_pkg::vdcr_pix_t pix_in,
    input wire logic clamp_ref,
    input wire logic [8:0] agc_auto_gain,
    output vdcr_pkg::vdcr_pix_t pix_out,
    output logic [2:0] current_standard,
    output logic shadow_enable,
    output logic [2:0] component_format,
    output logic test_input_sel,
    output logic test_output_sel,
    output logic clamp_pulse,
    output logic [8:0] agc_gain
);
    logic wait_q;
    logic [7:0] rdata_q;
    logic [7:0] cc_ctrl_q, brightness_offset_q, contr_q, sharp_q, cbg_q, crg_q, hue_q;
    logic [7:0] vpeak_q, coring_q, delta_q, test_q, clamp_q, agc_loop_gains_q, agc_lo_q, white_peak_threshold_q;
    logic [2:0] cc_stat_q;
    logic [3:0] std_sel_q;
    logic [6:0] std_rec_q;
    logic [3:0] comp_sel_q;
    logic agc_dis_q;
    logic [13:0] wss_bits_q;
    logic wss_field_q, wss_crc_q;
    logic [2:0] std_now_q;
    vdcr_pkg::vdcr_state_t state_q;
    vdcr_pkg::vdcr_ent_t fifo_mem [0:vdcr_pkg::FIFO_DEPTH-1];
    logic [4:0] wp_q, rp_q;
    logic ovf_q;
    logic [6:0] clamp_cnt_q;
    logic clamp_run_q, clamp_q_out;
    vdcr_pkg::vdcr_pix_t pix_q;
    logic [2:0] std_out_q, comp_out_q;
    logic shadow_q, tin_q, tout_q;
    logic [8:0] gain_q;

    // Bus decode: a read is captured on the first edge and a write on the second; both are answered one cycle later.
    wire logic [7:0] idx = avs_address[9:2];
    wire logic aligned = avs_address[1:0] == 2'b00;
    wire logic wr_en = avs_write & ~wait_q & aligned & avs_byteenable[0];
    wire logic rd_cap = avs_read & wait_q & aligned;
    wire logic [7:0] wd = avs_writedata[7:0];
    wire logic wr_cc_stat = wr_en & (idx == vdcr_pkg::IDX_CC_STAT);
    wire logic wr_std_sel = wr_en & (idx == vdcr_pkg::IDX_STD_SEL);
    wire logic wr_std_rec = wr_en & (idx == vdcr_pkg::IDX_STD_REC);

    // Caption FIFO state.
    wire logic [4:0] fifo_cnt = wp_q - rp_q;
    wire logic fifo_empty = fifo_cnt == 5'h0;
    wire logic fifo_full = fifo_cnt == 5'(vdcr_pkg::FIFO_DEPTH);
    wire vdcr_pkg::vdcr_ent_t head = fifo_mem[rp_q[3:0]];
    wire logic line_ok = cc_in.field_even | (cc_in.line == {4'h0, cc_ctrl_q[4:0]});
    wire logic src_en = cc_in.is_eds ? cc_stat_q[1] : cc_stat_q[0];
    wire logic push_req = cc_in.valid & line_ok & src_en;
    wire logic push = push_req & ~fifo_full;
    wire logic pop = rd_cap & (idx == vdcr_pkg::IDX_CAPTION_DATA) & ~fifo_empty;
    wire logic ovf_clr = rd_cap & (idx == vdcr_pkg::IDX_CC_STAT);
    wire vdcr_pkg::vdcr_ent_t push_ent = '{parity_err: ~^cc_in.data, is_eds: cc_in.is_eds,
        high: cc_in.high, data: cc_in.data};

    // Readback; unmapped indices read as zero.
    wire logic [7:0] cc_stat_rd = {cc_stat_q, head.parity_err & ~fifo_empty, ovf_q,
        ~fifo_empty, head.is_eds & ~fifo_empty, head.high & ~fifo_empty};
    wire logic [7:0] rd_word =
        (idx == vdcr_pkg::IDX_CC_CTRL) ? cc_ctrl_q :
        (idx == vdcr_pkg::IDX_WSS_HI) ? {wss_crc_q, wss_field_q, wss_bits_q[13:8]} :
        (idx == vdcr_pkg::IDX_WSS_LO) ? wss_bits_q[7:0] :
        (idx == vdcr_pkg::IDX_BRIGHTNESS_OFFSET) ? brightness_offset_q :
        (idx == vdcr_pkg::IDX_CONTR) ? contr_q :
        (idx == vdcr_pkg::IDX_SHARP) ? sharp_q :
        (idx == vdcr_pkg::IDX_CB_GAIN) ? cbg_q :
        (idx == vdcr_pkg::IDX_CR_GAIN) ? crg_q :
        (idx == vdcr_pkg::IDX_HUE) ? hue_q :
        (idx == vdcr_pkg::IDX_VPEAK) ? vpeak_q :
        (idx == vdcr_pkg::IDX_CORING) ? coring_q :
        (idx == vdcr_pkg::IDX_DELTA) ? delta_q :
        (idx == vdcr_pkg::IDX_CC_STAT) ? cc_stat_rd :
        (idx == vdcr_pkg::IDX_CAPTION_DATA) ? (fifo_empty ? 8'h00 : head.data) :
        (idx == vdcr_pkg::IDX_STD_SEL) ? {state_q == vdcr_pkg::VDCR_SEEK, std_now_q, std_sel_q} :
        (idx == vdcr_pkg::IDX_STD_REC) ? {1'b0, std_rec_q} :
        (idx == vdcr_pkg::IDX_COMP) ? {1'b0, component_detected, comp_sel_q} :
        (idx == vdcr_pkg::IDX_TEST) ? test_q :
        (idx == vdcr_pkg::IDX_CLAMP) ? clamp_q :
        (idx == vdcr_pkg::IDX_AGC_LOOP_GAINS) ? agc_loop_gains_q :
        (idx == vdcr_pkg::IDX_AGC_LO) ? agc_lo_q :
        (idx == vdcr_pkg::IDX_WHITE_PEAK_THRESHOLD) ? white_peak_threshold_q :
        (idx == vdcr_pkg::IDX_AGC_CTRL) ? {3'h0, agc_dis_q, 4'h0} : 8'h00;
    wire logic [7:0] rd_sel = aligned ? rd_word : 8'h00;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_q <= 1'b1;
            rdata_q <= 8'h00;
        end else begin
            wait_q <= ~((avs_read | avs_write) & wait_q);
            if (avs_read & wait_q) begin
                rdata_q <= rd_sel;
            end
        end
    end

    // Software-written registers.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cc_ctrl_q <= vdcr_pkg::RST_CC_CTRL;
            brightness_offset_q <= 8'h00;
            contr_q <= vdcr_pkg::RST_CONTR;
            sharp_q <= vdcr_pkg::RST_SHARP;
            cbg_q <= vdcr_pkg::RST_GAIN;
            crg_q <= vdcr_pkg::RST_GAIN;
            hue_q <= 8'h00;
            vpeak_q <= vdcr_pkg::RST_VPEAK;
            coring_q <= vdcr_pkg::RST_CORING;
            delta_q <= 8'h00;
            cc_stat_q <= 3'h0;
            std_sel_q <= vdcr_pkg::RST_STD_SEL;
            std_rec_q <= vdcr_pkg::RST_STD_REC;
            comp_sel_q <= vdcr_pkg::RST_COMP;
            test_q <= 8'h00;
            clamp_q <= vdcr_pkg::RST_CLAMP;
            agc_loop_gains_q <= vdcr_pkg::RST_AGC_LOOP_GAINS;
            agc_lo_q <= vdcr_pkg::RST_AGC_LO;
            white_peak_threshold_q <= vdcr_pkg::RST_WHITE_PEAK_THRESHOLD;
            agc_dis_q <= 1'b0;
        end else if (wr_en) begin
            case (idx)
                vdcr_pkg::IDX_CC_CTRL: cc_ctrl_q <= wd;
                vdcr_pkg::IDX_BRIGHTNESS_OFFSET: brightness_offset_q <= wd;
                vdcr_pkg::IDX_CONTR: contr_q <= wd;
                vdcr_pkg::IDX_SHARP: sharp_q <= wd;
                vdcr_pkg::IDX_CB_GAIN: cbg_q <= wd;
                vdcr_pkg::IDX_CR_GAIN: crg_q <= wd;
                vdcr_pkg::IDX_HUE: hue_q <= wd;
                vdcr_pkg::IDX_VPEAK: vpeak_q <= wd;
                vdcr_pkg::IDX_CORING: coring_q <= wd;
                vdcr_pkg::IDX_DELTA: delta_q <= wd;
                vdcr_pkg::IDX_CC_STAT: cc_stat_q <= wd[7:5];
                vdcr_pkg::IDX_STD_SEL: std_sel_q <= wd[3:0];
                vdcr_pkg::IDX_STD_REC: std_rec_q <= wd[6:0];
                vdcr_pkg::IDX_COMP: comp_sel_q <= wd[3:0];
                vdcr_pkg::IDX_TEST: test_q <= wd;
                vdcr_pkg::IDX_CLAMP: clamp_q <= wd;
                vdcr_pkg::IDX_AGC_LOOP_GAINS: agc_loop_gains_q <= wd;
                vdcr_pkg::IDX_AGC_LO: agc_lo_q <= wd;
                vdcr_pkg::IDX_WHITE_PEAK_THRESHOLD: white_peak_threshold_q <= wd;
                vdcr_pkg::IDX_AGC_CTRL: agc_dis_q <= wd[4];
                default: ;
            endcase
        end
    end

    // Sliced WSS words are latched only while decoding is enabled.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wss_bits_q <= 14'h0000;
            wss_field_q <= 1'b0;
            wss_crc_q <= 1'b0;
        end else if (wss_in.valid & cc_ctrl_q[5]) begin
            wss_bits_q <= wss_in.bits;
            wss_field_q <= wss_in.field_even;
            wss_crc_q <= ~wss_in.crc_ok;
        end
    end

    // Caption FIFO; an overflow seen in the clearing cycle stays set.
    always_ff @(posedge clock) begin
        if (push) begin
            fifo_mem[wp_q[3:0]] <= push_ent;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wp_q <= 5'h00;
            rp_q <= 5'h00;
            ovf_q <= 1'b0;
        end else begin
            wp_q <= wp_q + 5'(push);
            rp_q <= rp_q + 5'(pop);
            ovf_q <= (push_req & fifo_full) | (ovf_q & ~ovf_clr);
        end
    end

    // Standard detection. A manual selection overrides the search.
    wire logic sel_auto = std_sel_q[2:0] == vdcr_pkg::STD_AUTO;
    wire logic at_start = wr_std_rec & wd[7];
    wire logic auto_pick = wr_std_sel & (wd[2:0] == vdcr_pkg::STD_AUTO);
    wire logic std_hit = std_measured_valid & (std_measured != vdcr_pkg::STD_AUTO)
        & std_rec_q[std_measured];
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= vdcr_pkg::VDCR_IDLE;
            std_now_q <= 3'h0;
        end else begin
            case (state_q)
                vdcr_pkg::VDCR_IDLE: begin
                    if (at_start | auto_pick) begin
                        state_q <= vdcr_pkg::VDCR_SEEK;
                    end else if (!sel_auto) begin
                        std_now_q <= std_sel_q[2:0];
                    end else if (std_hit) begin
                        std_now_q <= std_measured;
                    end
                end
                vdcr_pkg::VDCR_SEEK: begin
                    if (wr_std_sel & ~auto_pick) begin
                        state_q <= vdcr_pkg::VDCR_IDLE;
                    end else if (std_hit) begin
                        std_now_q <= std_measured;
                        state_q <= vdcr_pkg::VDCR_IDLE;
                    end
                end
                default: state_q <= vdcr_pkg::VDCR_IDLE;
            endcase
        end
    end

    // Picture adjustment, one pipeline stage.
    function automatic logic [7:0] sat_u8(input logic signed [12:0] v);
        sat_u8 = (v < 0) ? 8'h00 : (v > 13'sd255) ? 8'hff : v[7:0];
    endfunction
    function automatic logic [7:0] sat_c8(input logic signed [12:0] v);
        logic signed [12:0] o;
        o = v + 13'sd128;
        sat_c8 = sat_u8(o);
    endfunction
    wire logic [15:0] y_gain = pix_in.y * contr_q;
    wire logic signed [12:0] y_sum = $signed({3'b000, y_gain[15:6]})
        + $signed({{5{brightness_offset_q[7]}}, brightness_offset_q});
    wire logic signed [7:0] cb_s = $signed({~pix_in.cb[7], pix_in.cb[6:0]});
    wire logic signed [7:0] cr_s = $signed({~pix_in.cr[7], pix_in.cr[6:0]});
    wire logic signed [15:0] h_cr = $signed(hue_q) * cr_s;
    wire logic signed [15:0] h_cb = $signed(hue_q) * cb_s;
    // Small-angle rotation: a positive hue moves Cr up, toward red.
    wire logic signed [9:0] cb_h = 10'(cb_s) - 10'(h_cr >>> 7);
    wire logic signed [9:0] cr_h = 10'(cr_s) + 10'(h_cb >>> 7);
    wire logic signed [18:0] cb_p = cb_h * $signed({1'b0, cbg_q});
    wire logic signed [18:0] cr_p = cr_h * $signed({1'b0, crg_q});
    wire logic signed [12:0] cb_n = 13'(cb_p >>> 7);
    wire logic signed [12:0] cr_n = 13'(cr_p >>> 7);

    // Clamp pulse window counted from the reference position.
    wire logic [6:0] clp_st = 7'(clamp_q[3:0] * vdcr_pkg::CLAMP_STEP);
    wire logic [6:0] clp_end = 7'(clamp_q[7:4] * vdcr_pkg::CLAMP_STEP);
    wire logic clamp_d = clamp_run_q & (clamp_cnt_q >= clp_st) & (clamp_cnt_q < clp_end);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pix_q <= '0;
            clamp_cnt_q <= 7'h00;
            clamp_run_q <= 1'b0;
            clamp_q_out <= 1'b0;
            std_out_q <= 3'h0;
            comp_out_q <= 3'h0;
            shadow_q <= 1'b0;
            tin_q <= 1'b0;
            tout_q <= 1'b0;
            gain_q <= 9'h000;
        end else begin
            pix_q <= '{valid: pix_in.valid, y: sat_u8(y_sum), cb: sat_c8(cb_n), cr: sat_c8(cr_n)};
            if (clamp_ref) begin
                clamp_cnt_q <= 7'h00;
                clamp_run_q <= 1'b1;
            end else if (clamp_run_q) begin
                clamp_cnt_q <= clamp_cnt_q + 7'h01;
                clamp_run_q <= clamp_cnt_q < clp_end;
            end
            clamp_q_out <= clamp_d;
            std_out_q <= std_now_q;
            shadow_q <= ~std_sel_q[3];
            comp_out_q <= (comp_sel_q == vdcr_pkg::COMP_AUTO) ? component_detected
                : comp_sel_q[2:0];
            tin_q <= test_q == vdcr_pkg::TEST_IN;
            tout_q <= test_q == vdcr_pkg::TEST_OUT;
            gain_q <= agc_dis_q ? {agc_loop_gains_q[0], agc_lo_q} : agc_auto_gain;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = {24'h00_0000, rdata_q};
    assign pix_out = pix_q;
    assign current_standard = std_out_q;
    assign shadow_enable = shadow_q;
    assign component_format = comp_out_q;
    assign test_input_sel = tin_q;
    assign test_output_sel = tout_q;
    assign clamp_pulse = clamp_q_out;
    assign agc_gain = gain_q;

    sequence s_cap_odd_miss;
        cc_in.valid & ~cc_in.field_even & (cc_in.line != {4'h0, cc_ctrl_q[4:0]}) & ~pop;
    endsequence
    sequence s_clamp_from_zero;
        clamp_ref & (clamp_q[3:0] == 4'h0) & (clamp_q[7:4] != 4'h0) ##1 ~clamp_ref [*2];
    endsequence
    property p_wss_gate;
        @(posedge clock) disable iff (!resetn) ~cc_ctrl_q[5] |=> $stable(wss_bits_q);
    endproperty
    a_wss_gate: assert property (p_wss_gate) else $error("WSS changed while disabled");
    property p_odd_line;
        @(posedge clock) disable iff (!resetn) s_cap_odd_miss |=> fifo_cnt == $past(fifo_cnt);
    endproperty
    a_odd_line: assert property (p_odd_line) else $error("caption taken on wrong line");
    property p_crc;
        @(posedge clock) disable iff (!resetn)
            wss_in.valid & cc_ctrl_q[5] |=> wss_crc_q == ~$past(wss_in.crc_ok);
    endproperty
    a_crc: assert property (p_crc) else $error("CRC flag wrong");
    property p_unity_luma;
        @(posedge clock) disable iff (!resetn)
            pix_in.valid & (contr_q == vdcr_pkg::UNITY_CONTR) & (brightness_offset_q == 8'h00)
            |=> pix_out.y == $past(pix_in.y);
    endproperty
    a_unity_luma: assert property (p_unity_luma) else $error("unity luma altered");
    property p_unity_cb;
        @(posedge clock) disable iff (!resetn)
            (cbg_q == vdcr_pkg::RST_GAIN) & (hue_q == 8'h00) |=> pix_out.cb == $past(pix_in.cb);
    endproperty
    a_unity_cb: assert property (p_unity_cb) else $error("unity chroma altered");
    property p_cap_gate;
        @(posedge clock) disable iff (!resetn)
            cc_in.valid & ~pop & ~(cc_in.is_eds ? cc_stat_q[1] : cc_stat_q[0])
            |=> fifo_cnt == $past(fifo_cnt);
    endproperty
    a_cap_gate: assert property (p_cap_gate) else $error("disabled source stored");
    property p_ovf;
        @(posedge clock) disable iff (!resetn) push_req & fifo_full |=> ovf_q;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");
    property p_pop;
        @(posedge clock) disable iff (!resetn)
            pop & ~push |=> (fifo_cnt == $past(fifo_cnt) - 5'h01) ##1 wait_q;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not pop");
    property p_start;
        @(posedge clock) disable iff (!resetn)
            at_start & (state_q == vdcr_pkg::VDCR_IDLE) |=> state_q == vdcr_pkg::VDCR_SEEK;
    endproperty
    a_start: assert property (p_start) else $error("detection did not start");
    property p_reject;
        @(posedge clock) disable iff (!resetn)
            (state_q == vdcr_pkg::VDCR_SEEK) & std_measured_valid & ~std_rec_q[std_measured]
            & ~wr_std_sel |=> state_q == vdcr_pkg::VDCR_SEEK;
    endproperty
    a_reject: assert property (p_reject) else $error("disabled standard accepted");
    property p_clamp;
        @(posedge clock) disable iff (!resetn) s_clamp_from_zero |-> clamp_pulse;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp pulse late");
    property p_manual_gain;
        @(posedge clock) disable iff (!resetn)
            agc_dis_q |=> agc_gain == {$past(agc_loop_gains_q[0]), $past(agc_lo_q)};
    endproperty
    a_manual_gain: assert property (p_manual_gain) else $error("manual gain unused");
endmodule

/* File: vdcr_video_src.sv */
// Model of the digitised video source feeding WSS and caption slicer pulses.
// Assumes the bench gives each command for one clock; pulses follow one edge later.
`timescale 1ns/1ns
module vdcr_video_src (
    input wire logic clock,
    input vdcr_pkg::vdcr_wss_t wss_cmd,
    input vdcr_pkg::vdcr_cc_t cc_cmd,
    output vdcr_pkg::vdcr_wss_t wss_out,
    output vdcr_pkg::vdcr_cc_t cc_out
);
    initial wss_out = '0;
    initial cc_out = '0;
    // Between pulses the data fields toggle, so a stale byte never looks steady.
    always @(posedge clock) begin
        wss_out <= wss_cmd.valid ? wss_cmd : {1'b0, ~wss_out[15:0]};
        cc_out <= cc_cmd.valid ? cc_cmd : {1'b0, ~cc_out[19:0]};
    end
endmodule

/* File: video_decoder_control_regs_tb_top.sv */
// Self-checking bench for the video decoder control registers.
// Assumes a 100 MHz clock; the bus master waits for waitrequest low, however long.
`timescale 1ns/1ns
module video_decoder_control_regs_tb_top;
    logic clock = 0, resetn = 0, avs_read = 0, avs_write = 0, smv = 0, clamp_ref = 0;
    logic [9:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic avs_waitrequest, shadow_enable, tis, tos, clamp_pulse;
    logic [2:0] std_m = '0, cur_std, comp_fmt;
    logic [8:0] agc_gain;
    vdcr_pkg::vdcr_wss_t wss_cmd = '0, wss_in;
    vdcr_pkg::vdcr_cc_t cc_cmd = '0, cc_in;
    vdcr_pkg::vdcr_pix_t pix_in = '0, pix_out;
    int mismatches = 0, comparisons = 0, n;
    logic [15:0] rdq;
    vdcr_video_src u_src (.clock(clock), .wss_cmd(wss_cmd), .cc_cmd(cc_cmd),
        .wss_out(wss_in), .cc_out(cc_in));
    vdcr_regs u_dut (.clock(clock), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wss_in(wss_in), .cc_in(cc_in), .std_measured(std_m), .std_measured_valid(smv),
        .component_detected(3'h2), .pix_in(pix_in), .clamp_ref(clamp_ref),
        .agc_auto_gain(9'h123), .pix_out(pix_out), .current_standard(cur_std),
        .shadow_enable(shadow_enable), .component_format(comp_fmt), .test_input_sel(tis),
        .test_output_sel(tos), .clamp_pulse(clamp_pulse), .agc_gain(agc_gain));
    initial forever #5 clock = ~clock;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {8'h00, e}, rdq);
    endtask
    task automatic cc(input logic [7:0] d, input logic s, h, ev, input logic [8:0] ln);
        cc_cmd <= '{1'b1, d, s, h, ev, ln};
        @(posedge clock);
        cc_cmd.valid <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic stdp(input logic [2:0] s);
        std_m <= s;
        smv <= 1'b1;
        @(posedge clock);
        smv <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic clamp(input logic [15:0] e);
        clamp_ref <= 1'b1;
        @(posedge clock);
        clamp_ref <= 1'b0;
        n = 0;
        repeat (160) begin
            @(posedge clock);
            n += (clamp_pulse === 1'b1);
        end
        chk("clamp width", e, n[15:0]);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rc(8'h0d, 8'h15);
        rc(8'h11, 8'h5c);
        rc(8'h13, 8'h80);
        rc(8'h14, 8'h80);
        rc(8'h20, 8'h50);
        rc(8'h22, 8'hf0);
        rc(8'h1e, 8'h28);
        rc(8'h1f, 8'h00);
        rc(8'h16, 8'h00);
        chk("auto component", 16'h0002, {13'h0000, comp_fmt});
        bus(1'b1, 8'h0d, 8'h35);
        wss_cmd <= '{1'b1, 14'h2a5c, 1'b1, 1'b0};
        @(posedge clock);
        wss_cmd.valid <= 1'b0;
        repeat (3) @(posedge clock);
        rc(8'h0e, 8'hea);
        rc(8'h0f, 8'h5c);
        bus(1'b1, 8'h0d, 8'h15);
        wss_cmd <= '{1'b1, 14'h0101, 1'b0, 1'b1};
        @(posedge clock);
        wss_cmd.valid <= 1'b0;
        repeat (3) @(posedge clock);
        rc(8'h0f, 8'h5c);
        bus(1'b1, 8'h1a, 8'h60);
        cc(8'h01, 1'b0, 1'b0, 1'b1, 9'h000);
        cc(8'h03, 1'b1, 1'b1, 1'b0, 9'h015);
        cc(8'h07, 1'b0, 1'b0, 1'b0, 9'h014);
        rc(8'h1a, 8'h64);
        rc(8'h1b, 8'h01);
        rc(8'h1a, 8'h77);
        rc(8'h1b, 8'h03);
        rc(8'h1a, 8'h60);
        bus(1'b1, 8'h1a, 8'h40);
        cc(8'h01, 1'b0, 1'b0, 1'b1, 9'h000);
        rc(8'h1a, 8'h40);
        bus(1'b1, 8'h1a, 8'h20);
        repeat (17) cc(8'h01, 1'b0, 1'b0, 1'b1, 9'h000);
        rc(8'h1a, 8'h2c);
        rc(8'h1a, 8'h24);
        pix_in <= '{1'b1, 8'h50, 8'h80, 8'h80};
        bus(1'b1, 8'h11, 8'h40);
        bus(1'b1, 8'h10, 8'h10);
        repeat (2) @(posedge clock);
        chk("luma", 16'h0060, {8'h00, pix_out.y});
        bus(1'b1, 8'h10, 8'hf0);
        repeat (2) @(posedge clock);
        chk("luma", 16'h0040, {8'h00, pix_out.y});
        chk("cb", 16'h0080, {8'h00, pix_out.cb});
        pix_in.y <= 8'h20;
        bus(1'b1, 8'h10, 8'h00);
        bus(1'b1, 8'h11, 8'h80);
        repeat (2) @(posedge clock);
        chk("luma", 16'h0040, {8'h00, pix_out.y});
        pix_in.cb <= 8'hc0;
        bus(1'b1, 8'h15, 8'h40);
        repeat (2) @(posedge clock);
        chk("cr", 16'h01a0, {7'h00, pix_out.valid, pix_out.cr});
        stdp(3'h3);
        rc(8'h1c, 8'h3f);
        bus(1'b1, 8'h1d, 8'hf7);
        stdp(3'h3);
        rc(8'h1c, 8'hbf);
        rc(8'h1d, 8'h77);
        stdp(3'h5);
        rc(8'h1c, 8'h5f);
        bus(1'b1, 8'h1c, 8'h02);
        repeat (2) @(posedge clock);
        chk("standard", 16'h000a, {12'h000, shadow_enable, cur_std});
        bus(1'b1, 8'h1e, 8'h01);
        repeat (2) @(posedge clock);
        chk("component", 16'h0001, {13'h0000, comp_fmt});
        bus(1'b1, 8'h1f, 8'h04);
        repeat (2) @(posedge clock);
        chk("test in", 16'h0002, {14'h0000, tis, tos});
        bus(1'b1, 8'h1f, 8'h07);
        repeat (2) @(posedge clock);
        chk("test out", 16'h0001, {14'h0000, tis, tos});
        chk("auto gain", 16'h0123, {7'h00, agc_gain});
        bus(1'b1, 8'h06, 8'h10);
        bus(1'b1, 8'h21, 8'h43);
        repeat (2) @(posedge clock);
        chk("manual gain", 16'h01f0, {7'h00, agc_gain});
        clamp(16'd40);
        bus(1'b1, 8'h20, 8'h52);
        clamp(16'd24);
        finish_test();
    end
endmodule
